// File: hdl/pmc_defines.svh
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_CONV 12'h008

// Control register fields
`define CTRL_VLP_BIT 0
`define CTRL_PSTOP_EN_BIT 1
`define CTRL_PSTOP_BUS_BIT 2
`define CTRL_VLP_RADIO_BIT 3

// Converter register fields
`define CONV_SW_SEL_BIT 0
`define CONV_SW_PULSED_BIT 1

// Reset values
`define CTRL_RST 4'h0
`define CONV_RST 2'h0

// Timing: flash access rate in low power run, MHz, and clock rate in MHz
`define FLASH_LP_MHZ 1
`define PCLK_MHZ 100
`define FLASH_DIV (`PCLK_MHZ / `FLASH_LP_MHZ)
`define CORE_LP_MHZ 4
`define CORE_DIV (`PCLK_MHZ / `CORE_LP_MHZ)

`endif

// File: hdl/pmc_pkg.sv
package pmc_pkg;
    typedef enum logic [3:0] {
        ST_RUN = 4'h0,
        ST_WAIT = 4'h1,
        ST_STOP = 4'h2,
        ST_PSTOP_BA = 4'h3,
        ST_PSTOP_BG = 4'h4,
        ST_VLP_RUN = 4'h5,
        ST_VLP_WAIT = 4'h6,
        ST_VLP_STOP = 4'h7
    } pmode_t;
endpackage : pmc_pkg

// File: hdl/rate_divider.sv
`timescale 1ns/10ps
module rate_divider #(
    parameter int DIV = 100
) (
    input wire logic pclk,          // Clock
    input wire logic presetn,       // Async reset, low
    input wire logic en,            // Run the divider
    output logic tick               // One-cycle enable pulse
);
    localparam int W = $clog2(DIV + 1);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic tick_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (!en) begin
            cnt_nxt = '0;
        end else if (cnt_r == W'(DIV - 1)) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick <= tick_nxt;
        end
    end
endmodule : rate_divider

// File: hdl/power_mode_controller.sv
`timescale 1ns/10ps
`include "pmc_defines.svh"
// Contract
// - Wait-for-interrupt enters stop when deep sleep select set, else wait.
// - Each run mode, normal or low power, has its own wait and stop.
// - Pin states are held unchanged in every power mode; io_hold holds them in wait and stop modes only, not in either run mode.
// - Normal wait stops CPU clock, peripherals run, interrupt resumes CPU.
// - Normal stop is static, registers kept, voltage detect on.
// - Partial stop bus active: core, system clocks gated; bus, generators run.
// - Partial stop bus gated: core, system, bus gated; generators run.
// - Low power run: 1MHz flash, regulator low power, detect off, 4MHz core.
// - Continuous converter disables biasing in low power run and wait.
// - Radio allowed in low power run only with continuous converter.
// - Low power wait is low power run with CPU asleep; interrupt wakes.
// - Strap low selects boost; strap high selects buck.
// - Continuous or pulsed chosen by hardware pin or software bit.
// - Power switch input controls converter power-up and bypass.
// - Power-stable output releases the chip power-on reset.
// - Radio logic kept in state retention during any stop mode.
module power_mode_controller (
    input wire logic pclk,                 // Clock, 100 MHz
    input wire logic presetn,              // Async reset, low
    input wire logic [11:0] paddr,         // APB address
    input wire logic psel,                 // APB select
    input wire logic penable,              // APB enable
    input wire logic pwrite,               // APB direction
    input wire logic [31:0] pwdata,        // APB write data
    output logic [31:0] prdata,            // APB read data
    output logic pready,                   // APB ready
    output logic pslverr,                  // APB error
    input wire logic wait_for_interrupt_instr, // Core sleep request pulse
    input wire logic deep_sleep_select,    // Core deep sleep bit
    input wire logic irq_pending,          // Any enabled interrupt, pin
    input wire logic cfg_strap,            // Converter strap pin
    input wire logic hw_pulsed,            // Hardware pulsed request pin
    input wire logic power_switch,         // Power switch pin
    input wire logic conv_output_ok,       // Converter output in range
    output logic cpu_clk_en,               // Core clock enable
    output logic sys_clk_en,               // System clock enable
    output logic bus_clk_en,               // Bus clock enable
    output logic bus_stop_req,             // Bus masters, slaves stop
    output logic clkgen_run,               // Clock generators running
    output logic reg_low_power,            // Regulator low power mode
    output logic low_voltage_detect,       // Low voltage detect enable
    output logic flash_tick,               // Low power flash access pulse
    output logic core_lp_tick,             // Low power core clock pulse
    output logic io_hold,                  // Pin state hold
    output logic radio_retain,             // Radio state retention
    output logic radio_allow,              // Radio operation permitted
    output logic conv_boost,               // Converter boost selected
    output logic conv_pulsed,              // Converter pulsed operation
    output logic conv_bias_en,             // Converter biasing enable
    output logic conv_bypass,              // Converter bypass
    output logic power_stable,             // Chip power-on reset release
    output pmc_pkg::pmode_t mode           // Current power mode
);
    import pmc_pkg::*;

    // Pin synchronisers
    // Only the second stage feeds logic; the first may be metastable
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic irq_s;
    logic strap_s;
    logic hwp_s;
    logic psw_s;
    logic ok_s;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= {conv_output_ok, power_switch, hw_pulsed, cfg_strap,
                        irq_pending};
            sync2_r <= sync1_r;
        end
    end
    assign irq_s = sync2_r[0];
    assign strap_s = sync2_r[1];
    assign hwp_s = sync2_r[2];
    assign psw_s = sync2_r[3];
    assign ok_s = sync2_r[4];

    // Registers
    logic [3:0] ctrl_r;
    logic [3:0] ctrl_nxt;
    logic [1:0] conv_r;
    logic [1:0] conv_nxt;
    logic [31:0] prdata_nxt;
    logic access;
    logic mapped;
    assign access = psel && penable;
    assign pready = 1'b1;
    assign mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) ||
                    (paddr == `OFS_CONV);
    // Unmapped accesses error; writes to them are dropped
    assign pslverr = access && !mapped;

    // Read data is taken in the setup cycle and stands through access
    always_comb begin
        ctrl_nxt = ctrl_r;
        conv_nxt = conv_r;
        prdata_nxt = prdata;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `OFS_CTRL: prdata_nxt = {28'h0, ctrl_r};
                `OFS_STATUS: prdata_nxt = {22'h0, power_stable, conv_bypass,
                    conv_pulsed, conv_boost, radio_retain, io_hold, mode};
                `OFS_CONV: prdata_nxt = {30'h0, conv_r};
                default: prdata_nxt = 32'h0;
            endcase
        end
        if (access && pwrite) begin
            if (paddr == `OFS_CTRL) begin
                ctrl_nxt = pwdata[3:0];
            end
            if (paddr == `OFS_CONV) begin
                conv_nxt = pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CTRL_RST;
            conv_r <= `CONV_RST;
            prdata <= 32'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            conv_r <= conv_nxt;
            prdata <= prdata_nxt;
        end
    end

    // Mode state machine
    pmode_t mode_r;
    pmode_t mode_nxt;
    logic vlp_run;
    assign mode = mode_r;

    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            ST_RUN, ST_VLP_RUN: begin
                vlp_run = (mode_r == ST_VLP_RUN);
                // A sleep request beats a run mode change
                if (wait_for_interrupt_instr) begin
                    if (deep_sleep_select) begin
                        // Partial stop is offered from normal run only
                        // per-run stop mode
                        if (vlp_run) begin
                            mode_nxt = ST_VLP_STOP;
                        end else if (ctrl_r[`CTRL_PSTOP_EN_BIT]) begin
                            mode_nxt = ctrl_r[`CTRL_PSTOP_BUS_BIT] ?
                                ST_PSTOP_BG : ST_PSTOP_BA;
                        end else begin
                            mode_nxt = ST_STOP;
                        end
                    end else begin
                        mode_nxt = vlp_run ? ST_VLP_WAIT : ST_WAIT;
                    end
                end else if (ctrl_r[`CTRL_VLP_BIT] != vlp_run) begin
                    mode_nxt = ctrl_r[`CTRL_VLP_BIT] ? ST_VLP_RUN : ST_RUN;
                end
            end
            ST_WAIT, ST_STOP, ST_PSTOP_BA, ST_PSTOP_BG, ST_VLP_WAIT,
            ST_VLP_STOP: begin
                vlp_run = 1'b0;
                // Wake sees the synchronised interrupt
                // wake to entering run mode
                if (irq_s) begin
                    mode_nxt = (mode_r == ST_VLP_WAIT ||
                        mode_r == ST_VLP_STOP) ? ST_VLP_RUN : ST_RUN;
                end
            end
            // Unused codes fall back to normal run
            default: begin
                vlp_run = 1'b0;
                mode_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= ST_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Clock and domain controls
    logic is_vlp;
    logic is_stop;
    logic cpu_nxt;
    logic sys_nxt;
    logic bus_nxt;
    logic bstop_nxt;
    always_comb begin
        is_vlp = (mode_r == ST_VLP_RUN) || (mode_r == ST_VLP_WAIT) ||
                 (mode_r == ST_VLP_STOP);
        is_stop = (mode_r == ST_STOP) || (mode_r == ST_VLP_STOP) ||
                  (mode_r == ST_PSTOP_BA) || (mode_r == ST_PSTOP_BG);
        cpu_nxt = (mode_r == ST_RUN) || (mode_r == ST_VLP_RUN);
        sys_nxt = cpu_nxt || (mode_r == ST_WAIT) || (mode_r == ST_VLP_WAIT);
        bus_nxt = sys_nxt || (mode_r == ST_PSTOP_BA);
        bstop_nxt = (mode_r == ST_PSTOP_BG) || (mode_r == ST_STOP) ||
                    (mode_r == ST_VLP_STOP);
    end

    // Registered so the clock gates never see a decode glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Reset leaves normal run with every clock on
            cpu_clk_en <= 1'b1;
            sys_clk_en <= 1'b1;
            bus_clk_en <= 1'b1;
            bus_stop_req <= 1'b0;
            clkgen_run <= 1'b1;
            reg_low_power <= 1'b0;
            low_voltage_detect <= 1'b1;
            radio_retain <= 1'b0;
            radio_allow <= 1'b1;
            conv_bias_en <= 1'b1;
        end else begin
            cpu_clk_en <= cpu_nxt;
            sys_clk_en <= sys_nxt;
            bus_clk_en <= bus_nxt;
            bus_stop_req <= bstop_nxt;
            clkgen_run <= (mode_r != ST_STOP) && (mode_r != ST_VLP_STOP);
            // regulator and detect in low power
            reg_low_power <= is_vlp;
            low_voltage_detect <= !is_vlp;
            radio_retain <= is_stop;
            // Pulsed converter cannot carry the radio in low power run
            // radio permission
            radio_allow <= !is_stop && (!is_vlp ||
                (!conv_pulsed && ctrl_r[`CTRL_VLP_RADIO_BIT]));
            // bias off in low power continuous
            conv_bias_en <= !(conv_pulsed == 1'b0 &&
                (mode_r == ST_VLP_RUN || mode_r == ST_VLP_WAIT));
        end
    end

    // Follows the registered core enable, so it cannot glitch
    // pins held in every wait and stop mode, not in low power run
    assign io_hold = !cpu_clk_en;

    // low power flash and core rates
    rate_divider #(
        .DIV(`FLASH_DIV)
    ) u_flash_div (
        .pclk(pclk),
        .presetn(presetn),
        .en(reg_low_power),
        .tick(flash_tick)
    );
    // Core rate stops and its count clears while the CPU sleeps
    // low power core rate while awake
    rate_divider #(
        .DIV(`CORE_DIV)
    ) u_core_div (
        .pclk(pclk),
        .presetn(presetn),
        .en(reg_low_power && cpu_clk_en),
        .tick(core_lp_tick)
    );

    // Converter controls
    logic boost_nxt;
    logic pulsed_nxt;
    always_comb begin
        boost_nxt = !strap_s;
        pulsed_nxt = conv_r[`CONV_SW_SEL_BIT] ?
            conv_r[`CONV_SW_PULSED_BIT] : hwp_s;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_boost <= 1'b0;
            conv_pulsed <= 1'b0;
            conv_bypass <= 1'b1;
            power_stable <= 1'b0;
        end else begin
            conv_boost <= boost_nxt;
            conv_pulsed <= pulsed_nxt;
            conv_bypass <= !psw_s;
            // Bypass needs no regulation, so supply is stable at once
            // stable when bypassed or output good
            power_stable <= !psw_s || ok_s;
        end
    end
endmodule : power_mode_controller

// File: verif/mode_chk.sv
`timescale 1ns/10ps
module mode_chk (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic wait_for_interrupt_instr, // Sleep
    input wire logic deep_sleep_select, // Deep
    input wire logic power_switch, // Switch
    input wire logic cpu_clk_en, // Core clk
    input wire logic sys_clk_en, // Sys clk
    input wire logic bus_clk_en, // Bus clk
    input wire logic bus_stop_req, // Bus stop
    input wire logic clkgen_run, // Gen run
    input wire logic reg_low_power, // Reg lp
    input wire logic low_voltage_detect, // Detect
    input wire logic io_hold, // Hold
    input wire logic radio_retain, // Retain
    input wire logic conv_bypass, // Bypass
    input wire pmc_pkg::pmode_t mode // Mode
);
    import pmc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_wfi_wait;
        wait_for_interrupt_instr && !deep_sleep_select && mode == ST_RUN
            |=> mode == ST_WAIT;
    endproperty
    a_wfi_wait: assert property (p_wfi_wait)
        else $error("no wait entry");
    property p_lp_sleep;
        wait_for_interrupt_instr && mode == ST_VLP_RUN |=> mode ==
            ($past(deep_sleep_select) ? ST_VLP_STOP : ST_VLP_WAIT);
    endproperty
    a_lp_sleep: assert property (p_lp_sleep)
        else $error("wrong low power sleep");
    property p_hold;
        $past(mode) == mode
            |-> io_hold == !(mode == ST_RUN || mode == ST_VLP_RUN);
    endproperty
    a_hold: assert property (p_hold)
        else $error("pin hold wrong");
    property p_wait_clk;
        mode == ST_WAIT && $past(mode) == ST_WAIT
            |-> !cpu_clk_en && sys_clk_en && bus_clk_en;
    endproperty
    a_wait_clk: assert property (p_wait_clk)
        else $error("wait clocks wrong");
    property p_stop;
        mode == ST_STOP && $past(mode) == ST_STOP
            |-> !cpu_clk_en && low_voltage_detect && radio_retain;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop outputs wrong");
    property p_pstop_ba;
        mode == ST_PSTOP_BA && $past(mode) == ST_PSTOP_BA |-> !sys_clk_en
            && bus_clk_en && !bus_stop_req && clkgen_run;
    endproperty
    a_pstop_ba: assert property (p_pstop_ba)
        else $error("partial stop bus active wrong");
    property p_pstop_bg;
        mode == ST_PSTOP_BG && $past(mode) == ST_PSTOP_BG
            |-> !bus_clk_en && bus_stop_req && clkgen_run;
    endproperty
    a_pstop_bg: assert property (p_pstop_bg)
        else $error("partial stop bus gated wrong");
    property p_lp_run;
        mode == ST_VLP_RUN && $past(mode) == ST_VLP_RUN
            |-> reg_low_power && !low_voltage_detect && cpu_clk_en;
    endproperty
    a_lp_run: assert property (p_lp_run)
        else $error("low power run outputs wrong");
    property p_bypass;
        $stable(power_switch) [*5] |-> conv_bypass == !power_switch;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass does not follow switch");
    c_stop: cover property (mode == ST_STOP);
    c_pstop_bg: cover property (mode == ST_PSTOP_BG);
    c_lp_stop: cover property (mode == ST_VLP_STOP);
endmodule : mode_chk
bind power_mode_controller mode_chk u_chk (
    .pclk(pclk), .presetn(presetn),
    .wait_for_interrupt_instr(wait_for_interrupt_instr),
    .deep_sleep_select(deep_sleep_select), .power_switch(power_switch),
    .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .bus_clk_en(bus_clk_en), .bus_stop_req(bus_stop_req),
    .clkgen_run(clkgen_run), .reg_low_power(reg_low_power),
    .low_voltage_detect(low_voltage_detect), .io_hold(io_hold),
    .radio_retain(radio_retain), .conv_bypass(conv_bypass), .mode(mode)
);

// File: verif/core_model.sv
`timescale 1ns/10ps
module core_model (
    input wire logic pclk, // Clock
    output logic wait_for_interrupt_instr, // Sleep pulse
    output logic deep_sleep_select, // Deep bit
    output logic irq_pending // Interrupt level
);
    initial begin
        wait_for_interrupt_instr = 1'b0;
        deep_sleep_select = 1'b0;
        irq_pending = 1'b0;
    end
    task sleep(input logic deep);
        @(posedge pclk);
        deep_sleep_select <= deep;
        wait_for_interrupt_instr <= 1'b1;
        @(posedge pclk);
        wait_for_interrupt_instr <= 1'b0;
    endtask : sleep
    task wake;
        @(posedge pclk);
        irq_pending <= 1'b1;
        repeat (6) @(posedge pclk);
        irq_pending <= 1'b0;
    endtask : wake
endmodule : core_model

// File: verif/testbench.sv
`timescale 1ns/10ps
`include "pmc_defines.svh"
module testbench;
    import pmc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic wait_for_interrupt_instr, deep_sleep_select, irq_pending;
    logic cfg_strap, hw_pulsed, power_switch, conv_output_ok;
    logic cpu_clk_en, sys_clk_en, bus_clk_en, bus_stop_req, clkgen_run;
    logic reg_low_power, low_voltage_detect, flash_tick, core_lp_tick;
    logic io_hold, radio_retain, radio_allow, conv_boost, conv_pulsed;
    logic conv_bias_en, conv_bypass, power_stable;
    logic [7:0] vec;
    pmode_t mode, org;
    int mismatches, check_count, ft, ct, f0, c0;
    logic [3:0] t_ctrl [6] = '{4'h0, 4'h0, 4'h2, 4'h6, 4'h1, 4'h1};
    logic [5:0] t_deep = 6'b101110;
    pmode_t t_mode [6] = '{ST_WAIT, ST_STOP, ST_PSTOP_BA, ST_PSTOP_BG,
        ST_VLP_WAIT, ST_VLP_STOP};
    logic [7:0] t_vec [6] = '{8'h62, 8'h03, 8'h29, 8'h19, 8'h04, 8'h01};
    logic [7:0] t_msk [6] = '{8'he2, 8'h87, 8'hf9, 8'hf9, 8'h86, 8'h83};
    power_mode_controller DUT (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .wait_for_interrupt_instr, .deep_sleep_select,
        .irq_pending, .cfg_strap, .hw_pulsed, .power_switch, .conv_output_ok,
        .cpu_clk_en, .sys_clk_en, .bus_clk_en, .bus_stop_req, .clkgen_run,
        .reg_low_power, .low_voltage_detect, .flash_tick, .core_lp_tick,
        .io_hold, .radio_retain, .radio_allow, .conv_boost, .conv_pulsed,
        .conv_bias_en, .conv_bypass, .power_stable, .mode
    );
    core_model core (
        .pclk, .wait_for_interrupt_instr, .deep_sleep_select, .irq_pending
    );
    assign vec = {cpu_clk_en, sys_clk_en, bus_clk_en, bus_stop_req,
        clkgen_run, reg_low_power, low_voltage_detect, radio_retain};
    always #5 pclk = ~pclk;
    // Tick counters, read by the main sequence
    always @(posedge pclk) begin
        if (flash_tick === 1'b1) ft <= ft + 1;
        if (core_lp_tick === 1'b1) ct <= ct + 1;
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    task check_word(input logic [31:0] got, input logic [31:0] exp,
        input logic [31:0] msk);
        check_count++;
        if ((got & msk) !== (exp & msk)) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : check_word
    task check_mode(input pmode_t got, input pmode_t exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: mode %h not %h", $time, got, exp);
        end
    endtask : check_mode
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            mismatches++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        end_of_test();
    end
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cfg_strap = 1'b1;
        hw_pulsed = 1'b0;
        power_switch = 1'b1;
        conv_output_ok = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check_word(vec, 8'hea, 8'hff);
        check_mode(mode, ST_RUN);
        apb(1'b0, `OFS_CTRL, 0);
        check_word(rd, 0, 32'hf);
        apb(1'b0, `OFS_CONV, 0);
        check_word(rd, 0, 32'h3);
        apb(1'b0, 12'h0f0, 0);
        check_word(err, 1, 1);
        check_word(rd, 0, '1);
        $display("test registers done");
        for (int i = 0; i < 2; i++) begin
            cfg_strap <= i[0];
            repeat (6) @(posedge pclk);
            check_word(conv_boost, !i[0], 1);
        end
        for (int i = 0; i < 8; i++) begin
            hw_pulsed <= i[2];
            apb(1'b1, `OFS_CONV, i[1:0]);
            repeat (6) @(posedge pclk);
            check_word(conv_pulsed, i[0] ? i[1] : i[2], 1);
        end
        for (int i = 0; i < 4; i++) begin
            power_switch <= i[0];
            conv_output_ok <= i[1];
            repeat (6) @(posedge pclk);
            apb(1'b0, `OFS_STATUS, 0);
            check_word(rd, {!i[0] | i[1], !i[0], 8'h0}, 32'h300);
        end
        $display("test converter done");
        hw_pulsed <= 1'b0;
        apb(1'b1, `OFS_CONV, 1);
        apb(1'b1, `OFS_CTRL, 9);
        repeat (8) @(posedge pclk);
        check_mode(mode, ST_VLP_RUN);
        check_word({conv_bias_en, radio_allow}, 2'b01, 3);
        f0 = ft;
        c0 = ct;
        repeat (1000) @(posedge pclk);
        check_word(ft - f0, 1000 / `FLASH_DIV, '1);
        check_word(ct - c0, 1000 / `CORE_DIV, '1);
        apb(1'b1, `OFS_CONV, 3);
        repeat (6) @(posedge pclk);
        check_word(radio_allow, 0, 1);
        apb(1'b1, `OFS_CONV, 0);
        $display("test low power run done");
        for (int i = 0; i < 6; i++) begin
            org = t_ctrl[i][0] ? ST_VLP_RUN : ST_RUN;
            apb(1'b1, `OFS_CTRL, t_ctrl[i]);
            repeat (8) @(posedge pclk);
            check_mode(mode, org);
            core.sleep(t_deep[i]);
            repeat (3) @(posedge pclk);
            check_mode(mode, t_mode[i]);
            check_word(vec, t_vec[i], t_msk[i]);
            check_word(io_hold, 1, 1);
            core.wake();
            repeat (4) @(posedge pclk);
            check_mode(mode, org);
            check_word(cpu_clk_en, 1, 1);
        end
        $display("test sleep modes done");
        end_of_test();
    end
endmodule : testbench
